// *** verilog/qes_defines.vh ***
// Constants for the quadrature encoder status block
`ifndef QES_DEFINES_VH
`define QES_DEFINES_VH

// ****************************************************************
// Register offsets (word addresses on the plain register port)
// ****************************************************************
`define QES_ADDR_W 4
`define QES_OFF_STATUS 4'h0
`define QES_OFF_CONTROL 4'h1
`define QES_OFF_LOWER 4'h2
`define QES_OFF_UPPER 4'h3
`define QES_OFF_COUNT_LOAD 4'h4

// ****************************************************************
// Status word fields
// ****************************************************************
`define QES_COUNT_W 24
`define QES_COUNT_MSB 23
`define QES_BIT_PHASE_A 24
`define QES_BIT_PHASE_B 25
`define QES_BIT_DIR 26
`define QES_BIT_IN_INTERVAL 27
`define QES_BIT_FRESH 28

// ****************************************************************
// Control word fields and reset values
// ****************************************************************
`define QES_CTL_INTERVAL_MODE 0
`define QES_CTL_NO_REACQ 1
`define QES_CONTROL_RESET 2'h0
`define QES_COUNT_RESET 24'h000000
`define QES_LOWER_RESET 24'h000000
`define QES_UPPER_RESET 24'hffffff

`endif

// *** verilog/qes_decoder.v ***
// Quadrature phase decoder producing one step per valid transition
`timescale 1ns/10ps
module qes_decoder (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire phase_a,
    input wire phase_b,
    output reg step_up,
    output reg step_down
);
    reg [1:0] prev_reg;
    wire [1:0] cur;
    assign cur = {phase_a, phase_b};

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_reg <= 2'h0;
        end else if (ce) begin
            prev_reg <= cur;
        end
    end

    // Gray sequence 00-10-11-01 is positive travel; double jumps are ignored as invalid
    always @* begin
        step_up = 1'b0;
        step_down = 1'b0;
        case ({prev_reg, cur})
            4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
                step_up = ce;
            end
            4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
                step_down = ce;
            end
            default: begin
                step_up = 1'b0;
            end
        endcase
    end
endmodule

// *** verilog/qes_top.v ***
// Quadrature encoder position and status block with line acquisition gating
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "qes_defines.vh"

// Operation
// - Status bits 23..0 hold position count
// - Status bit 24 shows phase A level
// - Status bit 25 shows phase B level
// - Bit 26 direction: 0 negative, 1 positive
// - Interval mode: bit 27 set inside limits
// - Outside limits bit 27 clear, no acquisition
// - Bit 28 set on unvisited lines, acquire
// - No-reacquire: acquire only lines never scanned
// - Bit 28 zero while revisiting old lines
module qes_top (
    input wire CORE_CLK,
    input wire RST,
    input wire CLK_EN,
    input wire PHASE_A,
    input wire PHASE_B,
    input wire [`QES_ADDR_W-1:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [31:0] REG_RDATA,
    output reg LINE_ACQUIRE
);
    // ****************************************************************
    // State
    // ****************************************************************
    reg [`QES_COUNT_MSB:0] position_count_reg;
    reg [`QES_COUNT_MSB:0] position_count_next;
    reg [`QES_COUNT_MSB:0] high_water_reg;
    reg [`QES_COUNT_MSB:0] high_water_next;
    reg [`QES_COUNT_MSB:0] interval_lower_limit_reg;
    reg [`QES_COUNT_MSB:0] interval_upper_limit_reg;
    reg [1:0] control_reg;
    reg motion_direction_reg;
    reg motion_direction_next;
    reg phase_a_level_reg;
    reg phase_b_level_reg;
    wire step_up;
    wire step_down;
    wire interval_mode_enable;
    wire no_reacquire_enable;
    wire inside_interval_flag;
    wire fresh_lines_flag;
    wire acquire_next;
    wire [31:0] status_word;

    assign interval_mode_enable = control_reg[`QES_CTL_INTERVAL_MODE];
    assign no_reacquire_enable = control_reg[`QES_CTL_NO_REACQ];

    // ****************************************************************
    // Phase decoding
    // ****************************************************************
    qes_decoder u_decoder (
        .clk(CORE_CLK),
        .rst(RST),
        .ce(CLK_EN),
        .phase_a(PHASE_A),
        .phase_b(PHASE_B),
        .step_up(step_up),
        .step_down(step_down)
    );

    // ****************************************************************
    // Position count, direction and high-water mark
    // ****************************************************************
    always @* begin
        position_count_next = position_count_reg;
        motion_direction_next = motion_direction_reg;
        if (step_up) begin
            position_count_next = position_count_reg + 24'h000001;
            motion_direction_next = 1'b1;
        end else if (step_down) begin
            position_count_next = position_count_reg - 24'h000001;
            motion_direction_next = 1'b0;
        end
    end

    // A line is fresh only once the count passes the farthest point reached so far
    assign fresh_lines_flag = (position_count_reg > high_water_reg);

    always @* begin
        high_water_next = high_water_reg;
        if (fresh_lines_flag) begin
            high_water_next = position_count_reg;
        end
    end

    // Limits are inclusive; a lower limit above the upper one makes an empty interval
    assign inside_interval_flag = interval_mode_enable &&
        (position_count_reg >= interval_lower_limit_reg) &&
        (position_count_reg <= interval_upper_limit_reg);

    // Acquisition gate: each enabled mode must agree before a line is taken
    assign acquire_next = (!interval_mode_enable || inside_interval_flag) &&
        (!no_reacquire_enable || fresh_lines_flag);

    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            position_count_reg <= `QES_COUNT_RESET;
            high_water_reg <= `QES_COUNT_RESET;
            motion_direction_reg <= 1'b1;
            phase_a_level_reg <= 1'b0;
            phase_b_level_reg <= 1'b0;
            LINE_ACQUIRE <= 1'b0;
        end else if (CLK_EN) begin
            phase_a_level_reg <= PHASE_A;
            phase_b_level_reg <= PHASE_B;
            motion_direction_reg <= motion_direction_next;
            LINE_ACQUIRE <= acquire_next;
            // Loading the count also rebases the high-water mark
            if (REG_WR && REG_ADDR == `QES_OFF_COUNT_LOAD) begin
                position_count_reg <= REG_WDATA[`QES_COUNT_MSB:0];
                high_water_reg <= REG_WDATA[`QES_COUNT_MSB:0];
            end else begin
                position_count_reg <= position_count_next;
                high_water_reg <= high_water_next;
            end
        end
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            control_reg <= `QES_CONTROL_RESET;
            interval_lower_limit_reg <= `QES_LOWER_RESET;
            interval_upper_limit_reg <= `QES_UPPER_RESET;
        end else if (CLK_EN && REG_WR) begin
            case (REG_ADDR)
                `QES_OFF_CONTROL: begin
                    control_reg <= REG_WDATA[1:0];
                end
                `QES_OFF_LOWER: begin
                    interval_lower_limit_reg <= REG_WDATA[`QES_COUNT_MSB:0];
                end
                `QES_OFF_UPPER: begin
                    interval_upper_limit_reg <= REG_WDATA[`QES_COUNT_MSB:0];
                end
                default: begin
                    control_reg <= control_reg;
                end
            endcase
        end
    end

    assign status_word = {3'h0,
        fresh_lines_flag,
        inside_interval_flag,
        motion_direction_reg,
        phase_b_level_reg,
        phase_a_level_reg,
        position_count_reg};

    // Read data stands for one enabled cycle after the strobe and holds while CLK_EN is low
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 32'h00000000;
        end else if (CLK_EN) begin
            if (REG_RD) begin
                case (REG_ADDR)
                    `QES_OFF_STATUS: REG_RDATA <= status_word;
                    `QES_OFF_CONTROL: REG_RDATA <= {30'h00000000, control_reg};
                    `QES_OFF_LOWER: REG_RDATA <= {8'h00, interval_lower_limit_reg};
                    `QES_OFF_UPPER: REG_RDATA <= {8'h00, interval_upper_limit_reg};
                    `QES_OFF_COUNT_LOAD: REG_RDATA <= {8'h00, position_count_reg};
                    default: REG_RDATA <= 32'h00000000;
                endcase
            end else begin
                REG_RDATA <= 32'h00000000;
            end
        end
    end
endmodule

// *** tb/qes_top_monitor.sv ***
// Assertion checker for the encoder status block
`timescale 1ns/10ps
`include "qes_defines.vh"
module qes_mon (
    input wire CORE_CLK,
    input wire RST,
    input wire CLK_EN,
    input wire PHASE_A,
    input wire PHASE_B,
    input wire [`QES_ADDR_W-1:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [31:0] REG_RDATA,
    input wire LINE_ACQUIRE
);
    wire [1:0] ab = {PHASE_A, PHASE_B};
    reg im_reg;
    reg nr_reg;
    // Shadow of the mode bits, so gating can be judged from the pins alone
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            im_reg <= 1'b0;
            nr_reg <= 1'b0;
        end else if (CLK_EN && REG_WR && REG_ADDR == `QES_OFF_CONTROL) begin
            im_reg <= REG_WDATA[`QES_CTL_INTERVAL_MODE];
            nr_reg <= REG_WDATA[`QES_CTL_NO_REACQ];
        end
    end
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    sequence stat_rd;
        CLK_EN && REG_RD && REG_ADDR == `QES_OFF_STATUS;
    endsequence
    sequence fwd_edge;
        CLK_EN && ab == 2'h0 ##1 CLK_EN && ab == 2'h2;
    endsequence
    sequence bwd_edge;
        CLK_EN && ab == 2'h0 ##1 CLK_EN && ab == 2'h1;
    endsequence
    chk_reserved_zero: assert property (stat_rd |=> REG_RDATA[31:29] == 3'h0)
        else $error("reserved bits set");
    chk_phase_bits: assert property (stat_rd ##0 $past(CLK_EN) |=> REG_RDATA[25:24] == {$past(PHASE_B, 2),
        $past(PHASE_A, 2)}) else $error("phase bits wrong");
    chk_dir_up: assert property (fwd_edge ##1 stat_rd |=> REG_RDATA[26])
        else $error("direction not positive");
    chk_dir_down: assert property (bwd_edge ##1 stat_rd |=> !REG_RDATA[26])
        else $error("direction not negative");
    chk_interval_off: assert property (stat_rd ##0 !im_reg |=> !REG_RDATA[27])
        else $error("interval flag without mode");
    chk_acq_outside: assert property (stat_rd ##0 im_reg ##1 !REG_RDATA[27] |-> !LINE_ACQUIRE)
        else $error("acquiring outside interval");
    chk_acq_fresh: assert property (stat_rd ##0 !im_reg ##1 REG_RDATA[28] |-> LINE_ACQUIRE)
        else $error("fresh line not acquired");
    chk_acq_old: assert property (stat_rd ##0 nr_reg ##1 !REG_RDATA[28] |-> !LINE_ACQUIRE)
        else $error("old line acquired");
endmodule
bind qes_top qes_mon u_mon (.CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN), .PHASE_A(PHASE_A), .PHASE_B(PHASE_B),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .LINE_ACQUIRE(LINE_ACQUIRE));

// *** tb/qes_enc_model.sv ***
// Behavioural incremental encoder driving the phase pins
`timescale 1ns/10ps
module qes_enc_model (
    input wire clk,
    input wire rst,
    input wire step,
    input wire up,
    output wire phase_a,
    output wire phase_b
);
    reg [1:0] pos_reg;
    // Gray order 00,10,11,01: only one phase moves per step
    assign phase_a = pos_reg == 2'h1 || pos_reg == 2'h2;
    assign phase_b = pos_reg[1];
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_reg <= 2'h0;
        end else if (step) begin
            pos_reg <= up ? pos_reg + 2'h1 : pos_reg - 2'h1;
        end
    end
endmodule

// *** tb/qes_top_tb_top.sv ***
// Self-checking bench for the encoder status block
`timescale 1ns/10ps
`include "qes_defines.vh"
module qes_top_tb_top;
    reg clk = 1'b0, rst = 1'b1, en = 1'b1, rd = 1'b0, wr = 1'b0, step = 1'b0, up = 1'b1, rd_d = 1'b0;
    reg [3:0] adr = 4'h0;
    reg [31:0] wd = 32'h0;
    reg [23:0] cnt = 24'h0, hw = 24'h0, lo = 24'h0, hi = 24'hffffff;
    reg im = 1'b0, nr = 1'b0;
    wire a, b, acq;
    wire [31:0] rdat;
    logic [31:0] q[$];
    integer bad_count = 0, checks_done = 0, cyc = 0, i;
    always #12.5 clk = ~clk;
    qes_enc_model enc (.clk(clk), .rst(rst), .step(step), .up(up), .phase_a(a), .phase_b(b));
    qes_top dut (.CORE_CLK(clk), .RST(rst), .CLK_EN(en), .PHASE_A(a), .PHASE_B(b), .REG_ADDR(adr), .REG_WDATA(wd),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .LINE_ACQUIRE(acq));
    task chk(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe while CLK_EN stays high
    always @(posedge clk) begin
        rd_d <= rd;
        cyc <= cyc + 1;
        if (rd_d) begin
            chk(rdat, q.pop_front());
        end
        if (cyc > 2000) begin
            bad_count = bad_count + 1;
            tally_and_finish;
        end
    end
    function [31:0] st;
        st = {3'h0, cnt > hw, im && cnt >= lo && cnt <= hi, up, b, a, cnt};
    endfunction
    task wrt(input [3:0] ad, input [31:0] d);
        adr <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // Idle edge so a following write never re-raises the strobe in the same step
        @(posedge clk);
    endtask
    task rdx(input [3:0] ad, input [31:0] e);
        q.push_back(e);
        adr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Status is read in the cycle the new count first shows, so a fresh line is still flagged
    task mv(input u, input integer n);
        for (i = 0; i < n; i = i + 1) begin
            up <= u;
            step <= 1'b1;
            @(posedge clk);
            step <= 1'b0;
            cnt = u ? cnt + 24'h1 : cnt - 24'h1;
            @(posedge clk);
            rdx(`QES_OFF_STATUS, st());
            if (cnt > hw) hw = cnt;
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk({31'h0, acq}, {31'h0, (!im || (cnt >= lo && cnt <= hi)) && !nr});
            @(posedge clk);
        end
    endtask
    initial begin
        i = $urandom(32'hade977a6);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdx(`QES_OFF_STATUS, st());
        wrt(`QES_OFF_STATUS, $urandom);
        rdx(4'hf, 32'h0);
        wrt(4'h7, $urandom);
        rdx(`QES_OFF_STATUS, st());
        cnt = 24'h100 + ($urandom & 24'hfff);
        hw = cnt;
        wrt(`QES_OFF_COUNT_LOAD, {8'h0, cnt});
        mv(1'b1, 6);
        $display("test forward done");
        nr = 1'b1;
        wrt(`QES_OFF_CONTROL, 32'h2);
        mv(1'b0, 3);
        mv(1'b1, 5);
        $display("test revisit done");
        lo = cnt + 24'h2;
        hi = cnt + 24'h3;
        wrt(`QES_OFF_LOWER, {8'h0, lo});
        wrt(`QES_OFF_UPPER, {8'h0, hi});
        wrt(`QES_OFF_CONTROL, 32'h1);
        im = 1'b1;
        nr = 1'b0;
        mv(1'b1, 5);
        mv(1'b0, 2);
        $display("test interval done");
        rst <= 1'b1;
        up <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        {cnt, hw, lo, hi, im} = {24'h0, 24'h0, 24'h0, 24'hffffff, 1'b0};
        @(posedge clk);
        rdx(`QES_OFF_STATUS, st());
        // A write while the clock enable is low must leave control untouched
        en <= 1'b0;
        wrt(`QES_OFF_CONTROL, 32'h3);
        en <= 1'b1;
        rdx(`QES_OFF_CONTROL, 32'h0);
        repeat (2) @(posedge clk);
        $display("test reset done");
        tally_and_finish;
    end
endmodule
